// File: design/sysbus_port.sv
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module sysbus_port
  import sysbus_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Ownership and strobes
  input  wire logic        external_request_n,
  output logic             bus_release_n,
  output logic             out_valid_n,
  input  wire logic        in_valid_n,
  input  wire logic        read_accept_n,
  input  wire logic        write_accept_n,
  input  wire logic        invalidate_ack_n,
  input  wire logic        invalidate_error_n,
  // Shared buses
  input  wire logic [63:0] sys_addr_data_in,
  output logic [63:0]      sys_addr_data_out,
  output logic [63:0]      sys_addr_data_oe,
  input  wire logic [8:0]  sys_command_in,
  output logic [8:0]       sys_command_out,
  output logic [8:0]       sys_command_oe,
  input  wire logic [7:0]  sys_check_bits_in,
  output logic [7:0]       sys_check_bits_out,
  output logic [7:0]       sys_check_bits_oe,
  // Boot mode serial loader
  input  wire logic        supply_good,
  output logic             mode_clk,
  input  wire logic        mode_data,
  // Decoded mode settings
  output logic             block_order_sel,
  output logic             check_mode_sel,
  output logic             byte_order_sel,
  output logic             dirty_shared_disable,
  output logic             no_second_cache,
  output logic [1:0]       second_cache_line_size,
  output logic [3:0]       transmit_data_pattern,
  output logic [2:0]       bus_clock_divisor,
  output logic             timer_int_disable,
  output logic             potential_inval_disable
);

  // ====
  // State
  typedef struct packed {
    port_state_t           st;       // Port state
    logic [7:0]            div;      // Mode clock divider
    logic [8:0]            bits;     // Mode bits taken
    logic                  loaded;   // Mode load complete
    logic                  sg;       // Supply good seen
    logic [MODE_KEEP-1:0]  mode;     // Kept mode bits
    logic                  pend;     // Request waiting
    logic [1:0]            kind;     // Request kind
    logic                  pot;      // Potential invalidate
    logic [63:0]           addr;     // Request address
    logic [63:0]           wdata;    // Write data
    logic                  rd_out;   // Read outstanding
    logic                  ack_wait; // Invalidate outcome due
    logic                  inv_ok;   // Sticky success
    logic                  inv_err;  // Sticky failure
    logic                  rx_new;   // Sticky receive
    logic [8:0]            rx_cmd;   // Last received command
    logic [63:0]           rx_data;  // Last received word
    logic [8:0]            snoop;    // Line state for snoop
    logic [31:0]           resp;     // Data for ext reads
    logic [63:0]           drv_ad;   // Driven address/data
    logic [8:0]            drv_cmd;  // Driven command
    logic [7:0]            drv_chk;  // Driven check bits
    logic                  oe;       // Driving the buses
    logic                  valid;    // Out-valid strobe
    logic                  rel;      // Release strobe
  } state_t;

  state_t s_reg;  // Registered state
  state_t s_next; // Next state

  // ====
  // Helpers
  // Byte swap for big endian words
  function automatic logic [63:0] swap(input logic [63:0] d,
                                       input logic en);
    logic [63:0] r;
    r = d;
    if (en) begin
      for (int i = 0; i < 8; i++) begin
        r[i*8 +: 8] = d[(7-i)*8 +: 8];
      end
    end
    return r;
  endfunction

  // Check bits: byte parity, or a folded code in ECC mode
  function automatic logic [7:0] check(input logic [63:0] d,
                                       input logic par);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (par) begin
        r[i] = ^d[i*8 +: 8];
      end else begin
        for (int j = 0; j < 8; j++) begin
          r[i] = r[i] ^ d[j*8 + ((i + j) % 8)];
        end
      end
    end
    return r;
  endfunction

  logic        apb_wr;    // Write access phase
  logic        hit;       // Mapped address
  logic        accept;    // Agent accepts request
  logic [2:0]  ext_code;  // External request code
  logic [8:0]  req_cmd;   // Outgoing command word
  logic [63:0] out_word;  // Outgoing data word

  // ====
  // APB decode and read mux
  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      OFF_CTRL:   prdata = {29'h0, s_reg.pot, s_reg.kind};
      OFF_ADDR_L: prdata = s_reg.addr[31:0];
      OFF_ADDR_H: prdata = s_reg.addr[63:32];
      OFF_DATA_L: prdata = s_reg.wdata[31:0];
      OFF_DATA_H: prdata = s_reg.wdata[63:32];
      OFF_STATUS: prdata = {21'h0,
                            (transmit_data_pattern > PAT_MAX) ||
                            (bus_clock_divisor > RAT_MAX),
                            s_reg.st, s_reg.rx_new, s_reg.inv_err,
                            s_reg.inv_ok, s_reg.ack_wait,
                            s_reg.rd_out, s_reg.pend, s_reg.loaded};
      OFF_MODE:   prdata = {11'h0, s_reg.mode};
      OFF_RX_CMD: prdata = {23'h0, s_reg.rx_cmd};
      OFF_RX_L:   prdata = s_reg.rx_data[31:0];
      OFF_RX_H:   prdata = s_reg.rx_data[63:32];
      OFF_SNOOP:  prdata = {23'h0, s_reg.snoop};
      OFF_RESP:   prdata = s_reg.resp;
      default: begin
        prdata = 32'h0;
        hit    = 1'b0;
      end
    endcase
  end

  // Zero-wait slave, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign apb_wr  = psel && penable && pwrite && hit;

  assign accept  = (s_reg.kind == KIND_WRITE) ? !write_accept_n
                                              : !read_accept_n;
  assign ext_code = sys_command_in[CMD_LAST-1 -: 3];

  always_comb begin
    req_cmd = 9'h000;
    req_cmd[CMD_LAST-1 -: 3] = {1'b0, s_reg.kind};
    req_cmd[CMD_POT] = s_reg.pot && !s_reg.mode[MB_POT];
  end

  assign out_word = swap(s_reg.wdata, s_reg.mode[MB_END]);

  // ====
  // Next-state logic
  always_comb begin
    s_next       = s_reg;
    s_next.rel   = 1'b0;
    s_next.valid = 1'b0;

    // Software register writes
    if (apb_wr) begin
      unique case (paddr)
        OFF_CTRL: begin
          // New request only when slot free
          if (!s_reg.pend) begin
            s_next.pend = 1'b1;
            s_next.kind = pwdata[1:0];
            s_next.pot  = pwdata[CTRL_POT];
          end
        end
        OFF_ADDR_L: s_next.addr[31:0]   = pwdata;
        OFF_ADDR_H: s_next.addr[63:32]  = pwdata;
        OFF_DATA_L: s_next.wdata[31:0]  = pwdata;
        OFF_DATA_H: s_next.wdata[63:32] = pwdata;
        OFF_STATUS: begin
          // Write one to clear sticky bits
          if (pwdata[4]) s_next.inv_ok  = 1'b0;
          if (pwdata[5]) s_next.inv_err = 1'b0;
          if (pwdata[6]) s_next.rx_new  = 1'b0;
        end
        OFF_SNOOP: s_next.snoop = pwdata[8:0];
        OFF_RESP:  s_next.resp  = pwdata;
        default: ;
      endcase
    end

    // divider runs once supply is good
    s_next.sg = s_reg.sg || supply_good;
    if (s_reg.sg) begin
      s_next.div = s_reg.div + 8'h01;
      // take a bit per mode clock rise
      if (s_reg.div == DIV_HALF && !s_reg.loaded) begin
        if (s_reg.bits < 9'(MODE_KEEP)) begin
          s_next.mode[s_reg.bits[4:0]] = mode_data;
        end
        s_next.bits = s_reg.bits + 9'h001;
        if (s_reg.bits == 9'(MODE_BITS - 1)) begin
          s_next.loaded = 1'b1;
        end
      end
    end

    if (s_reg.ack_wait) begin
      if (!invalidate_ack_n) begin
        s_next.inv_ok   = 1'b1;
        s_next.ack_wait = 1'b0;
      end else if (!invalidate_error_n) begin
        s_next.inv_err  = 1'b1;
        s_next.ack_wait = 1'b0;
      end
    end

    unique case (s_reg.st)
      ST_BOOT: begin
        s_next.oe = 1'b0;
        if (s_reg.loaded) s_next.st = ST_IDLE;
      end

      ST_IDLE: begin
        s_next.oe = 1'b0;
        if (!external_request_n ||
            (s_reg.rd_out && !s_reg.pend)) begin
          s_next.rel = 1'b1;
          s_next.st  = ST_SLAVE;
        end else if (s_reg.pend &&
                     !((s_reg.rd_out || s_reg.ack_wait) &&
                       s_reg.mode[MB_NOSC])) begin
          s_next.oe      = 1'b1;
          s_next.valid   = 1'b1;
          s_next.drv_ad  = s_reg.addr;
          s_next.drv_cmd = req_cmd;
          s_next.drv_chk = check(s_reg.addr, s_reg.mode[MB_CHK]);
          s_next.st      = ST_ISSUE;
        end
      end

      ST_ISSUE: begin
        s_next.valid = 1'b1;
        if (accept) begin
          if (s_reg.kind == KIND_WRITE) begin
            s_next.drv_ad  = out_word;
            s_next.drv_cmd = 9'h000;
            s_next.drv_cmd[CMD_DATA] = 1'b1;
            s_next.drv_cmd[CMD_LAST] = 1'b1;
            s_next.drv_chk = check(out_word, s_reg.mode[MB_CHK]);
            s_next.st      = ST_WDATA;
          end else begin
            s_next.valid = 1'b0;
            s_next.oe    = 1'b0;
            s_next.pend  = 1'b0;
            if (s_reg.kind == KIND_READ) begin
              s_next.rd_out = 1'b1;
              if (s_reg.mode[MB_NOSC]) begin
                s_next.rel = 1'b1;
                s_next.st  = ST_SLAVE;
              end else begin
                // overlap: back to idle, which then releases the bus since pend is now clear
                s_next.st = ST_IDLE;
              end
            end else begin
              s_next.ack_wait = 1'b1;
              s_next.st       = ST_IDLE;
            end
          end
        end
      end

      ST_WDATA: begin
        // Single data word, then done
        s_next.oe   = 1'b0;
        s_next.pend = 1'b0;
        s_next.st   = ST_IDLE;
      end

      ST_SLAVE: begin
        s_next.oe = 1'b0;
        if (!in_valid_n) begin
          s_next.rx_cmd  = sys_command_in;
          s_next.rx_data = swap(sys_addr_data_in, s_reg.mode[MB_END]);
          s_next.rx_new  = 1'b1;
          if (sys_command_in[CMD_DATA]) begin
            if (sys_command_in[CMD_LAST]) s_next.rd_out = 1'b0;
          end else begin
            unique case (ext_code)
              EXT_SNOOP: begin
                s_next.oe      = 1'b1;
                s_next.valid   = 1'b1;
                s_next.drv_cmd = s_reg.snoop;
                s_next.st      = ST_RESP;
              end
              EXT_READ, EXT_INTV: begin
                s_next.oe      = 1'b1;
                s_next.valid   = 1'b1;
                s_next.drv_ad  = {32'h0, s_reg.resp};
                s_next.drv_cmd = 9'h000;
                s_next.drv_cmd[CMD_DATA] = 1'b1;
                s_next.drv_cmd[CMD_LAST] = 1'b1;
                s_next.drv_chk = check({32'h0, s_reg.resp},
                                       s_reg.mode[MB_CHK]);
                s_next.st      = ST_RESP;
              end
              EXT_NULL: s_next.st = ST_IDLE;
              default: ;
            endcase
          end
        end else if (external_request_n && !s_reg.rd_out) begin
          // Agent done, take the bus back
          s_next.st = ST_IDLE;
        end
      end

      ST_RESP: begin
        // One answer cycle, stay in slave state
        s_next.oe = 1'b0;
        s_next.st = ST_SLAVE;
      end

      default: s_next.st = ST_BOOT;
    endcase
  end

  // ====
  // State register, frozen while enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ====
  // Outputs
  assign bus_release_n      = !s_reg.rel;
  assign out_valid_n        = !s_reg.valid;
  assign sys_addr_data_out  = s_reg.drv_ad;
  assign sys_command_out    = s_reg.drv_cmd;
  assign sys_check_bits_out = s_reg.drv_chk;
  assign sys_addr_data_oe   = {64{s_reg.oe}};
  assign sys_command_oe     = {9{s_reg.oe}};
  assign sys_check_bits_oe  = {8{s_reg.oe}};
  assign mode_clk           = s_reg.div[7];

  assign block_order_sel         = s_reg.mode[MB_BLK];
  assign check_mode_sel          = s_reg.mode[MB_CHK];
  assign byte_order_sel          = s_reg.mode[MB_END];
  assign dirty_shared_disable    = s_reg.mode[MB_DSH];
  assign no_second_cache         = s_reg.mode[MB_NOSC];
  assign second_cache_line_size  = s_reg.mode[MB_LINE_LO +: 2];
  assign transmit_data_pattern   = s_reg.mode[MB_PAT_LO +: 4];
  assign bus_clock_divisor       = s_reg.mode[MB_RAT_LO +: 3];
  assign timer_int_disable       = s_reg.mode[MB_TIM];
  assign potential_inval_disable = s_reg.mode[MB_POT];

endmodule // sysbus_port

// File: inc/sysbus_pkg.sv
package sysbus_pkg;
  // ====
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR_L = 8'h04;
  localparam logic [7:0] OFF_ADDR_H = 8'h08;
  localparam logic [7:0] OFF_DATA_L = 8'h0C;
  localparam logic [7:0] OFF_DATA_H = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MODE   = 8'h18;
  localparam logic [7:0] OFF_RX_CMD = 8'h1C;
  localparam logic [7:0] OFF_RX_L   = 8'h20;
  localparam logic [7:0] OFF_RX_H   = 8'h24;
  localparam logic [7:0] OFF_SNOOP  = 8'h28;
  localparam logic [7:0] OFF_RESP   = 8'h2C;
  // ====
  // Processor request kinds (CTRL[1:0])
  localparam logic [1:0] KIND_READ  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_INVAL = 2'h2;
  localparam logic [1:0] KIND_UPD   = 2'h3;
  localparam int         CTRL_POT   = 2;
  // ====
  // Command bus layout
  localparam int         CMD_DATA   = 8;
  localparam int         CMD_LAST   = 7;
  localparam int         CMD_POT    = 0;
  localparam logic [2:0] EXT_READ   = 3'h0;
  localparam logic [2:0] EXT_WRITE  = 3'h1;
  localparam logic [2:0] EXT_INVAL  = 3'h2;
  localparam logic [2:0] EXT_UPD    = 3'h3;
  localparam logic [2:0] EXT_SNOOP  = 3'h4;
  localparam logic [2:0] EXT_INTV   = 3'h5;
  localparam logic [2:0] EXT_NULL   = 3'h6;
  // ====
  // Boot mode stream
  localparam int         MODE_DIV   = 256;
  localparam int         MODE_BITS  = 256;
  localparam int         MODE_KEEP  = 21;
  localparam logic [7:0] DIV_HALF   = 8'h7F;
  localparam int         MB_BLK     = 0;
  localparam int         MB_CHK     = 1;
  localparam int         MB_END     = 2;
  localparam int         MB_DSH     = 3;
  localparam int         MB_NOSC    = 4;
  localparam int         MB_LINE_LO = 9;
  localparam int         MB_PAT_LO  = 11;
  localparam int         MB_RAT_LO  = 15;
  localparam int         MB_TIM     = 19;
  localparam int         MB_POT     = 20;
  localparam logic [3:0] PAT_MAX    = 4'h8;
  localparam logic [2:0] RAT_MAX    = 3'h4;
  // ====
  // Port states
  typedef enum logic [2:0] {
    ST_BOOT  = 3'b000,
    ST_IDLE  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WDATA = 3'b011,
    ST_SLAVE = 3'b100,
    ST_RESP  = 3'b101
  } port_state_t;
endpackage

// File: testbench/sysbus_port_props.sv
`timescale 1ns/10ps
module sysbus_port_props
  import sysbus_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Strobes
  input wire logic        external_request_n,
  input wire logic        bus_release_n,
  input wire logic        out_valid_n,
  input wire logic        in_valid_n,
  input wire logic        read_accept_n,
  input wire logic        write_accept_n,
  // Buses and modes
  input wire logic [63:0] sys_addr_data_out,
  input wire logic [63:0] sys_addr_data_oe,
  input wire logic [8:0]  sys_command_in,
  input wire logic [8:0]  sys_command_out,
  input wire logic [8:0]  sys_command_oe,
  input wire logic [7:0]  sys_check_bits_out,
  input wire logic        check_mode_sel,
  input wire logic        no_second_cache,
  input wire logic        mode_clk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // Helper logic
  logic       rd_acc;    // Read request taken this cycle
  logic       rd_out;    // Read data still owed
  logic       mclk_q;    // Mode clock one cycle ago
  logic       mclk_seen; // Mode clock has started
  logic [7:0] hcnt;      // Cycles since last mode clock edge
  assign rd_acc = !out_valid_n && !sys_command_out[CMD_DATA]
                  && sys_command_out[5:4] == KIND_READ && !read_accept_n;
  // Track outstanding read and mode clock half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_out    <= 1'b0;
      mclk_q    <= 1'b0;
      mclk_seen <= 1'b0;
      hcnt      <= 8'h00;
    end else begin
      mclk_q <= mode_clk;
      hcnt   <= (mode_clk != mclk_q) ? 8'h00 : hcnt + 8'h01;
      if (mode_clk != mclk_q) mclk_seen <= 1'b1;
      // Cleared only by the last data word from the agent
      if (rd_acc && no_second_cache) rd_out <= 1'b1;
      else if (!in_valid_n && sys_command_in[8:7] == 2'b11) rd_out <= 1'b0;
    end
  end
  // ====================
  // Assertions
  chk_release_pulse: assert property (
    $fell(bus_release_n) |=> bus_release_n)
    else $error("Release too long");
  chk_ext_release: assert property (
    $fell(external_request_n) && out_valid_n && bus_release_n && in_valid_n
    |-> ##[1:4] !bus_release_n)
    else $error("No release on request");
  chk_valid_drive: assert property (
    !out_valid_n |-> sys_command_oe == 9'h1FF)
    else $error("Valid without drive");
  chk_one_outstanding: assert property (
    rd_out |-> out_valid_n)
    else $error("Issue during read");
  chk_read_release: assert property (
    rd_acc && no_second_cache
    |=> out_valid_n && !bus_release_n && sys_addr_data_oe == 64'h0)
    else $error("No release after read");
  chk_addr_hold: assert property (
    !out_valid_n && !sys_command_out[CMD_DATA] && read_accept_n
    && write_accept_n |=> !out_valid_n && $stable(sys_addr_data_out)
    && $stable(sys_command_out))
    else $error("Request dropped early");
  chk_write_data: assert property (
    !out_valid_n && !sys_command_out[CMD_DATA]
    && sys_command_out[5:4] == KIND_WRITE && !write_accept_n
    |=> !out_valid_n && sys_command_out[8:7] == 2'b11 ##1 out_valid_n)
    else $error("Write data missing");
  chk_snoop_answer: assert property (
    !in_valid_n && !sys_command_in[CMD_DATA]
    && sys_command_in[6:4] == EXT_SNOOP
    |=> !out_valid_n && sys_command_oe == 9'h1FF)
    else $error("Snoop unanswered");
  chk_mode_period: assert property (
    mclk_seen && mode_clk != mclk_q |-> hcnt == 8'h7F)
    else $error("Mode clock period wrong");
  chk_check_parity: assert property (
    !out_valid_n && check_mode_sel && sys_addr_data_oe[0]
    |-> {sys_check_bits_out[7], sys_check_bits_out[0]}
    == {^sys_addr_data_out[63:56], ^sys_addr_data_out[7:0]})
    else $error("Check parity wrong");
endmodule // sysbus_port_props

bind sysbus_port sysbus_port_props u_props (.*);

// File: testbench/sysbus_agent.sv
`timescale 1ns/10ps
module sysbus_agent
  import sysbus_pkg::*;
#(
  parameter logic [20:0] MODE_WORD = 21'h000000,
  parameter logic [63:0] RD_WORD   = 64'h0
)(
  // Clock, reset, supply
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        supply_good,
  // From the device
  input wire logic        mode_clk,
  input wire logic        bus_release_n,
  input wire logic        out_valid_n,
  input wire logic [8:0]  sys_command_out,
  // To the device
  output logic            mode_data,
  output logic            external_request_n,
  output logic            in_valid_n,
  output logic            read_accept_n,
  output logic            write_accept_n,
  output logic            invalidate_ack_n,
  output logic            invalidate_error_n,
  output logic [63:0]     sys_addr_data_in,
  output logic [8:0]      sys_command_in
);
  int   idx    = 0;    // Next mode bit
  int   waited = 0;    // Cycles current request stalled
  int   rcnt   = 0;    // Delay before read data
  int   stall  = 0;    // Stall length, set by the bench
  logic fail   = 1'b0; // Report failure on next inval/update
  logic rd_pend = 1'b0;
  logic ext_on  = 1'b0; // Bench-driven request owns the bus
  initial begin
    {external_request_n, in_valid_n, read_accept_n} = 3'b111;
    {write_accept_n, invalidate_ack_n, invalidate_error_n} = 3'b111;
    sys_addr_data_in = 64'h0;
    sys_command_in   = 9'h000;
  end
  assign mode_data = (idx < 21) ? MODE_WORD[idx] : 1'b0;
  always @(negedge mode_clk) if (supply_good) idx <= idx + 1;
  // Accepts, completion and read data
  always @(posedge pclk) begin
    waited <= (out_valid_n || sys_command_out[CMD_DATA]) ? 0 : waited + 1;
    read_accept_n  <= !(!out_valid_n && waited >= stall);
    write_accept_n <= !(!out_valid_n && waited >= stall);
    invalidate_ack_n   <= 1'b1;
    invalidate_error_n <= 1'b1;
    if (!out_valid_n && !read_accept_n && !sys_command_out[CMD_DATA]) begin
      if (sys_command_out[5:4] == KIND_READ) rd_pend <= 1'b1;
      if (sys_command_out[5]) begin
        invalidate_ack_n   <= fail;
        invalidate_error_n <= !fail;
      end
    end
    // data only after release; idle bus shows noise
    if (!ext_on) begin
      in_valid_n <= !(rcnt == 1);
      sys_addr_data_in <= (rcnt == 1) ? RD_WORD : ~sys_addr_data_in;
      if (rcnt == 1) sys_command_in <= 9'h180;
    end
    if (rcnt == 1) rd_pend <= 1'b0;
    if (rcnt > 0) rcnt <= rcnt - 1;
    else if (rd_pend && !bus_release_n) rcnt <= 12;
  end
  // external request with command and address
  task automatic ext_req(input logic [2:0] code);
    int n;
    @(posedge pclk);
    ext_on = 1'b1;
    external_request_n <= 1'b0;
    for (n = 0; n < 20 && bus_release_n !== 1'b0; n++) @(posedge pclk);
    in_valid_n       <= 1'b0;
    sys_command_in   <= {2'b00, code, 4'h0};
    sys_addr_data_in <= 64'h0000_0000_0000_1040;
    @(posedge pclk);
    if (code == EXT_WRITE) begin
      sys_command_in   <= 9'h180;
      sys_addr_data_in <= 64'h55AA_0FF0_1234_ABCD;
      @(posedge pclk);
    end
    in_valid_n         <= 1'b1;
    external_request_n <= 1'b1;
    ext_on = 1'b0;
  endtask
endmodule // sysbus_agent

// File: testbench/tb_processor_system_bus_port.sv
`timescale 1ns/10ps
module tb_processor_system_bus_port;
  import sysbus_pkg::*;
  localparam logic [20:0] MODE_WORD = 21'h09AC1B;
  // ====================
  // Signals
  logic pclk = 0, presetn = 0, supply_good = 0, err;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic external_request_n, bus_release_n, out_valid_n, in_valid_n;
  logic read_accept_n, write_accept_n, invalidate_ack_n;
  logic invalidate_error_n, mode_clk, mode_data;
  logic [63:0] sys_addr_data_in, sys_addr_data_out, sys_addr_data_oe;
  logic [8:0]  sys_command_in, sys_command_out, sys_command_oe;
  logic block_order_sel, check_mode_sel, byte_order_sel;
  logic dirty_shared_disable, no_second_cache, timer_int_disable;
  logic potential_inval_disable;
  logic [1:0]  second_cache_line_size;
  logic [3:0]  transmit_data_pattern;
  logic [2:0]  bus_clock_divisor;
  int bad_count = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  // ====================
  // Device and agent
  sysbus_port dut (.*, .ce(1'b1), .sys_check_bits_in(8'h00),
    .sys_check_bits_out(), .sys_check_bits_oe());
  sysbus_agent #(.MODE_WORD(MODE_WORD), .RD_WORD(64'hCAFE_0001_8765_4321))
    ag (.*);
  // ====================
  // Shared tasks
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for the request strobe
  task automatic wait_valid;
    for (int n = 0; n < 20 && out_valid_n !== 1'b0; n++) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ====================
  // Scenarios
  task automatic t_boot;
    @(posedge pclk);
    supply_good <= 1'b1;
    r = 32'h0;
    // Load takes 256 slow clocks, so poll sparsely
    for (int n = 0; n < 2000 && r[0] !== 1'b1; n++) begin
      repeat (64) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0, r);
    end
    chk(r[10], 1'b0);
    apb(1'b0, OFF_MODE, 32'h0, r);
    chk(r[20:0], MODE_WORD);
    chk({block_order_sel, check_mode_sel, byte_order_sel}, 3'b110);
    chk({dirty_shared_disable, no_second_cache}, 2'b11);
    chk({second_cache_line_size, transmit_data_pattern}, 6'h25);
    chk(bus_clock_divisor, 3'h3);
    chk({timer_int_disable, potential_inval_disable}, 2'b10);
    apb(1'b0, 8'h3C, 32'h0, r);
    chk(err, 1'b1);
    $display("test boot done");
  endtask
  task automatic t_read;
    ag.stall = 3;
    apb(1'b1, OFF_ADDR_L, 32'h1234_5678, r);
    apb(1'b1, OFF_ADDR_H, 32'h9ABC_DEF0, r);
    apb(1'b1, OFF_CTRL, {30'h0, KIND_READ}, r);
    wait_valid();
    chk(sys_addr_data_out, 64'h9ABC_DEF0_1234_5678);
    chk(sys_command_out[5:4], KIND_READ);
    for (int n = 0; n < 20 && bus_release_n !== 1'b0; n++) @(posedge pclk);
    chk({out_valid_n, sys_addr_data_oe}, {1'b1, 64'h0});
    apb(1'b0, OFF_STATUS, 32'h0, r);
    chk(r[2], 1'b1);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFF_RX_L, 32'h0, r);
    chk(r, 32'h8765_4321);
    apb(1'b0, OFF_RX_H, 32'h0, r);
    chk(r, 32'hCAFE_0001);
    $display("test read done");
  endtask
  task automatic t_write;
    ag.stall = 4;
    apb(1'b1, OFF_DATA_L, 32'h0BAD_F00D, r);
    apb(1'b1, OFF_DATA_H, 32'h1357_9BDF, r);
    apb(1'b1, OFF_ADDR_L, 32'h0000_2000, r);
    apb(1'b1, OFF_ADDR_H, 32'h0, r);
    apb(1'b1, OFF_CTRL, {30'h0, KIND_WRITE}, r);
    wait_valid();
    chk(sys_command_out[5:4], KIND_WRITE);
    for (int n = 0; n < 20 && sys_command_out[CMD_DATA] !== 1'b1; n++)
      @(posedge pclk);
    chk({out_valid_n, sys_command_out[8:7]}, 3'b011);
    chk(sys_addr_data_out, 64'h1357_9BDF_0BAD_F00D);
    $display("test write done");
  endtask
  // Invalidate succeeds, update fails
  task automatic t_inval;
    ag.stall = 0;
    for (int k = 0; k < 2; k++) begin
      ag.fail = k[0];
      apb(1'b1, OFF_CTRL, {29'h0, 1'b1, k[0] ? KIND_UPD : KIND_INVAL}, r);
      wait_valid();
      chk(sys_command_out[CMD_POT], 1'b1);
      repeat (10) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 32'h0, r);
      chk(r[5:4], k[0] ? 2'b10 : 2'b01);
      apb(1'b1, OFF_STATUS, 32'h30, r);
      apb(1'b0, OFF_STATUS, 32'h0, r);
      chk(r[5:4], 2'b00);
    end
    $display("test inval done");
  endtask
  task automatic t_ext;
    apb(1'b1, OFF_SNOOP, 32'h1A5, r);
    for (int c = 0; c < 7; c++) begin
      ag.ext_req(c[2:0]);
      @(posedge pclk);
      if (c == EXT_SNOOP)
        chk({out_valid_n, sys_command_out}, 10'h1A5);
      repeat (8) @(posedge pclk);
      apb(1'b0, OFF_RX_CMD, 32'h0, r);
      chk(r[8:0], c == EXT_WRITE ? 9'h180 : {2'b00, c[2:0], 4'h0});
    end
    $display("test external done");
  endtask
  // ====================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge pclk);
    chk({bus_release_n, out_valid_n, mode_clk}, 3'b110);
    presetn <= 1'b1;
    t_boot();
    t_read();
    t_write();
    t_inval();
    t_ext();
    close_out();
  end
  initial begin
    repeat (90000) @(posedge pclk);
    bad_count++;
    close_out();
  end
endmodule // tb_processor_system_bus_port
